/* File: logic/btmc_map.svh */
`ifndef BTMC_MAP_SVH
`define BTMC_MAP_SVH

// register address on the serial frame (7-bit address field)
`define BTMC_ADDR        7'h04
`define BTMC_ADDR_W      7

// field positions inside the 16-bit register
`define BTMC_RSVD_HI     15
`define BTMC_RSVD_LO     8
`define BTMC_FLASH_BIT   7
`define BTMC_LSM_BIT     6
`define BTMC_TXTO_BIT    5
`define BTMC_LIN_HI      4
`define BTMC_LIN_LO      3
`define BTMC_CAN_HI      2
`define BTMC_CAN_LO      0

// reset and forced values
`define BTMC_POR_VAL     8'h00
`define BTMC_RSVD_VAL    8'h00
`define BTMC_SDM_CAN     3'h1
`define BTMC_SDM_LIN     2'h3
`define BTMC_FS_LIN      2'h1
`define BTMC_FS_CAN_LO   2'h1
`define BTMC_RST_CAN_LO  2'h0
`define BTMC_WAKE_CAN_LO 2'h1
`define BTMC_RX_CAN_LO   2'h2
`define BTMC_NRM_CAN_LO  2'h3

`endif

/* File: logic/btmc_pkg.sv */
`default_nettype none
package btmc_pkg;

   // single wire transceiver modes
   typedef enum logic [1:0] {
      BTMC_LIN_OFF    = 2'b00,
      BTMC_LIN_WAKE   = 2'b01,
      BTMC_LIN_RX     = 2'b10,
      BTMC_LIN_NORMAL = 2'b11
   } btmc_lin_mode_t;

   // the stored register bits 7:0; can keeps raw bits, 101..111 can be written
   typedef struct packed {
      logic           slope_bypass_flash;
      logic           low_slope_select;
      logic           tx_dominant_timeout_enable;
      btmc_lin_mode_t single_wire_transceiver_mode;
      logic [2:0]     hs_transceiver_mode;
   } btmc_reg_t;

endpackage
`default_nettype wire

/* File: logic/btmc_upd_if.sv */
`default_nettype none
interface btmc_upd_if;
   import btmc_pkg::*;

   btmc_reg_t cur;
   logic      sleep_entry;
   logic      stop_entry;
   logic      system_error_enable_en;
   btmc_reg_t lowpwr;

   modport core (output cur, output sleep_entry, output stop_entry,
                 output system_error_enable_en, input lowpwr);
   modport upd  (input cur, input sleep_entry, input stop_entry,
                 input system_error_enable_en, output lowpwr);
endinterface
`default_nettype wire

/* File: logic/btmc_lowpwr_update.sv */
`include "btmc_map.svh"
`default_nettype none
module btmc_lowpwr_update
   import btmc_pkg::*;
(
   btmc_upd_if.upd u
);

   // low two bits of the can field decide; the msb is never touched
   wire [1:0] can_lo     = u.cur.hs_transceiver_mode[1:0];
   wire       can_msb    = u.cur.hs_transceiver_mode[2];
   wire       is_normal  = (can_lo == `BTMC_NRM_CAN_LO);
   wire       is_rx      = (can_lo == `BTMC_RX_CAN_LO);

   // normal falls back to wake only when system error is off
   wire       nrm_to_wk  = u.sleep_entry & ~u.system_error_enable_en & is_normal;
   // receive only goes to wake on sleep, stays on stop
   wire       rx_to_wk   = u.sleep_entry & is_rx;
   // wake and off codes fall through untouched
   // only a low-power entry may move the field at all
   wire       lp_entry   = u.sleep_entry | u.stop_entry;
   wire       go_wake    = lp_entry & (nrm_to_wk | rx_to_wk);
   wire [1:0] nxt_can_lo = go_wake ? `BTMC_WAKE_CAN_LO : can_lo;

   // rebuild the register with the msb carried over as is
   always_comb begin
      u.lowpwr                     = u.cur;
      u.lowpwr.hs_transceiver_mode = {can_msb, nxt_can_lo};
   end

endmodule
`default_nettype wire

/* File: logic/btmc_top.sv */
// Notes on behaviour
// - upper eight bits read zero, ignore writes
// - bit 7 switches lin slope control off
// - bit 6 selects lin low-slope mode
// - bit 5 enables lin transmit time-out
// - lin mode field, software and device update
// - can mode field, five listed codes
// - restart loads pattern, y from cause
// - device changes can mode msb only on reset load
// - sleep, no system_error_enable, normal becomes wake
// - receive only: sleep wake, stop stays
// - wake or off codes stay unchanged
// - fail-safe forces lin wake and can low bits wake, can msb kept
// - dev mode reset loads can 001 lin 11
`include "btmc_map.svh"
`default_nettype none
module btmc_top
   import btmc_pkg::*;
(
   input  wire logic                     i_mclk,
   input  wire logic                     i_rstn,
   input  wire logic [`BTMC_ADDR_W-1:0]  i_reg_addr,
   input  wire logic                     i_reg_wr,
   input  wire logic [15:0]              i_reg_wdata,
   input  wire logic                     i_reg_rd,
   output logic      [15:0]              o_reg_rdata,
   input  wire logic                     i_soft_reset,
   input  wire logic                     i_restart,
   input  wire logic                     i_restart_lin_hi,
   input  wire logic                     i_failsafe_entry,
   input  wire logic                     i_sleep_entry,
   input  wire logic                     i_stop_entry,
   input  wire logic                     i_system_error_enable,
   input  wire logic                     i_sw_dev_mode,
   output logic                          o_slope_bypass_flash,
   output logic                          o_low_slope_select,
   output logic                          o_tx_dominant_timeout_enable,
   output logic      [1:0]               o_lin_mode,
   output logic      [2:0]               o_can_mode,
   output logic                          o_lin_tx_on,
   output logic                          o_lin_rx_on,
   output logic                          o_lin_wake_on,
   output logic                          o_can_tx_on,
   output logic                          o_can_rx_on,
   output logic                          o_can_wake_on
);

   // stored register, pending power-on load and registered read data
   btmc_reg_t   mode_ff;
   btmc_reg_t   nxt_mode;
   logic        por_pend_ff;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;

   // registered decoded transceiver enables
   logic        lin_tx_ff;
   logic        lin_rx_ff;
   logic        lin_wk_ff;
   logic        can_tx_ff;
   logic        can_rx_ff;
   logic        can_wk_ff;
   logic        nxt_lin_tx;
   logic        nxt_lin_rx;
   logic        nxt_lin_wk;
   logic        nxt_can_tx;
   logic        nxt_can_rx;
   logic        nxt_can_wk;

   // address decode for the host access
   wire         hit      = (i_reg_addr == `BTMC_ADDR);
   wire         host_wr  = i_reg_wr & hit;
   wire         host_rd  = i_reg_rd & hit;
   wire         low_pwr  = i_sleep_entry | i_stop_entry;

   // host write value: only the low byte is stored
   btmc_reg_t   wr_val;
   assign wr_val = btmc_reg_t'(i_reg_wdata[`BTMC_FLASH_BIT:0]);

   // power-on and soft reset value, with the development mode option
   wire [1:0]   por_lin  = i_sw_dev_mode ? `BTMC_SDM_LIN : 2'h0;
   wire [2:0]   por_can  = i_sw_dev_mode ? `BTMC_SDM_CAN : 3'h0;
   btmc_reg_t   por_val;
   always_comb begin
      por_val                              = btmc_reg_t'(`BTMC_POR_VAL);
      por_val.single_wire_transceiver_mode = btmc_lin_mode_t'(por_lin);
      por_val.hs_transceiver_mode          = por_can;
   end

   // restart pattern xx0y 0x00: x bits held, y from the restart cause
   btmc_reg_t   rst_val;
   always_comb begin
      rst_val                              = mode_ff;
      rst_val.tx_dominant_timeout_enable   = 1'b0;
      rst_val.single_wire_transceiver_mode =
         btmc_lin_mode_t'({i_restart_lin_hi, 1'b0});
      rst_val.hs_transceiver_mode          =
         {mode_ff.hs_transceiver_mode[2], `BTMC_RST_CAN_LO};
   end

   // fail-safe pattern xxx0 1x01: lin left wake capable, can too unless the msb is set
   btmc_reg_t   fs_val;
   always_comb begin
      fs_val                               = mode_ff;
      fs_val.single_wire_transceiver_mode  =
         btmc_lin_mode_t'(`BTMC_FS_LIN);
      // the msb stays with software even here; only the reset load clears it
      fs_val.hs_transceiver_mode           =
         {mode_ff.hs_transceiver_mode[2], `BTMC_FS_CAN_LO};
   end

   // low-power adjustments come from the update module
   btmc_upd_if  upd ();
   assign upd.cur         = mode_ff;
   assign upd.sleep_entry = i_sleep_entry;
   assign upd.stop_entry  = i_stop_entry;
   assign upd.system_error_enable_en   = i_system_error_enable;

   btmc_lowpwr_update u_lowpwr (
      .u (upd.upd)
   );

   // device events win over a host write in the same cycle, since the
   // device must be sure the transceivers can still wake it afterwards
   wire         use_por  = por_pend_ff | i_soft_reset;
   assign nxt_mode = use_por          ? por_val    :
                     i_restart        ? rst_val    :
                     i_failsafe_entry ? fs_val     :
                     low_pwr          ? upd.lowpwr :
                     host_wr          ? wr_val     :
                     mode_ff;

   // register state; the strap is caught by a clocked load after release
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         mode_ff     <= btmc_reg_t'(`BTMC_POR_VAL);
         por_pend_ff <= 1'b1;
      end else begin
         mode_ff     <= nxt_mode;
         por_pend_ff <= 1'b0;
      end
   end

   // read data: upper byte always zero, unmapped address reads zero
   assign nxt_rdata = host_rd ? {`BTMC_RSVD_VAL, mode_ff} :
                      i_reg_rd ? 16'h0000 : rdata_ff;

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_ff <= 16'h0000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // single wire transceiver enables decoded from the next state
   wire [1:0]   n_lin   = nxt_mode.single_wire_transceiver_mode;
   assign nxt_lin_tx = (n_lin == BTMC_LIN_NORMAL);
   assign nxt_lin_rx = (n_lin == BTMC_LIN_NORMAL) |
                       (n_lin == BTMC_LIN_RX);
   assign nxt_lin_wk = (n_lin == BTMC_LIN_WAKE);

   // can enables; any code with the msb set is off, so 100 and the
   // unlisted codes leave the transceiver quiet
   wire [2:0]   n_can   = nxt_mode.hs_transceiver_mode;
   wire         can_ok  = ~n_can[2];
   assign nxt_can_tx = can_ok & (n_can[1:0] == `BTMC_NRM_CAN_LO);
   assign nxt_can_rx = can_ok & n_can[1];
   assign nxt_can_wk = can_ok & (n_can[1:0] == `BTMC_WAKE_CAN_LO);

   // enable flops track the register in the same edge
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         lin_tx_ff <= 1'b0;
         lin_rx_ff <= 1'b0;
         lin_wk_ff <= 1'b0;
         can_tx_ff <= 1'b0;
         can_rx_ff <= 1'b0;
         can_wk_ff <= 1'b0;
      end else begin
         lin_tx_ff <= nxt_lin_tx;
         lin_rx_ff <= nxt_lin_rx;
         lin_wk_ff <= nxt_lin_wk;
         can_tx_ff <= nxt_can_tx;
         can_rx_ff <= nxt_can_rx;
         can_wk_ff <= nxt_can_wk;
      end
   end

   // field outputs straight from the register
   assign o_slope_bypass_flash         = mode_ff.slope_bypass_flash;
   assign o_low_slope_select           = mode_ff.low_slope_select;
   assign o_tx_dominant_timeout_enable =
      mode_ff.tx_dominant_timeout_enable;
   assign o_lin_mode = mode_ff.single_wire_transceiver_mode;
   assign o_can_mode = mode_ff.hs_transceiver_mode;

   // decoded enables and read data
   assign o_lin_tx_on   = lin_tx_ff;
   assign o_lin_rx_on   = lin_rx_ff;
   assign o_lin_wake_on = lin_wk_ff;
   assign o_can_tx_on   = can_tx_ff;
   assign o_can_rx_on   = can_rx_ff;
   assign o_can_wake_on = can_wk_ff;
   assign o_reg_rdata   = rdata_ff;

endmodule
`default_nettype wire

/* File: testbench/btmc_top_props.sv */
`include "btmc_map.svh"
`default_nettype none
module btmc_top_props (
   input wire logic                    i_mclk,
   input wire logic                    i_rstn,
   input wire logic [`BTMC_ADDR_W-1:0] i_reg_addr,
   input wire logic                    i_reg_wr,
   input wire logic [15:0]             i_reg_wdata,
   input wire logic [15:0]             o_reg_rdata,
   input wire logic                    i_soft_reset,
   input wire logic                    i_restart,
   input wire logic                    i_restart_lin_hi,
   input wire logic                    i_failsafe_entry,
   input wire logic                    i_sleep_entry,
   input wire logic                    i_stop_entry,
   input wire logic                    i_system_error_enable,
   input wire logic                    i_sw_dev_mode,
   input wire logic [1:0]              o_lin_mode,
   input wire logic [2:0]              o_can_mode,
   input wire logic                    o_can_tx_on,
   input wire logic                    o_can_rx_on,
   input wire logic                    o_can_wake_on,
   input wire logic                    o_slope_bypass_flash,
   input wire logic                    o_low_slope_select,
   input wire logic                    o_tx_dominant_timeout_enable,
   input wire logic                    o_lin_tx_on,
   input wire logic                    o_lin_rx_on,
   input wire logic                    o_lin_wake_on
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   // the first edge after release loads the power-on value, so skip it
   logic run_ff;
   always_ff @(posedge i_mclk or negedge i_rstn)
      if (!i_rstn) run_ff <= 1'b0;
      else run_ff <= 1'b1;
   wire logic hit = i_reg_wr && (i_reg_addr == `BTMC_ADDR);
   wire logic up  = i_soft_reset | i_restart | i_failsafe_entry;
   wire logic ev  = up | i_sleep_entry | i_stop_entry;
   wire logic [1:0] cl = o_can_mode[1:0];
   a_rsvd_zero: assert property (o_reg_rdata[15:8] == 8'h00)
      else $error("upper read bits not zero");
   a_write_lands: assert property (run_ff && hit && !ev |=>
      {o_lin_mode, o_can_mode} == $past(i_reg_wdata[4:0]))
      else $error("write did not land");
   a_msb_kept: assert property (run_ff && !hit && !i_soft_reset
      |=> $stable(o_can_mode[2])) else $error("can msb moved");
   a_sleep_wake: assert property (run_ff && !up && i_sleep_entry &&
      (cl == 2'h2 || (cl == 2'h3 && !i_system_error_enable)) |=> cl == 2'h1)
      else $error("sleep did not select wake");
   a_stop_keep: assert property (run_ff && !up && !i_sleep_entry &&
      i_stop_entry |=> $stable({o_lin_mode, o_can_mode}))
      else $error("stop changed modes");
   a_low_keep: assert property (run_ff && !up && i_sleep_entry &&
      !o_can_mode[1] |=> $stable(o_can_mode)) else $error("off/wake moved");
   a_restart_load: assert property (run_ff && !i_soft_reset &&
      i_restart |=> cl == 2'h0 && o_lin_mode == {$past(i_restart_lin_hi),
      1'b0}) else $error("restart pattern wrong");
   a_failsafe_load: assert property (run_ff && !i_soft_reset &&
      !i_restart && i_failsafe_entry |=> o_lin_mode == 2'h1 && cl == 2'h1)
      else $error("fail-safe pattern wrong");
   a_dev_reset: assert property (run_ff && i_soft_reset |=>
      {o_lin_mode, o_can_mode} == {{2{$past(i_sw_dev_mode)}}, 2'h0,
      $past(i_sw_dev_mode)}) else $error("soft reset value wrong");
   a_can_decode: assert property (o_can_tx_on == (o_can_mode == 3'h3) &&
      o_can_rx_on == (o_can_mode[2:1] == 2'h1) &&
      o_can_wake_on == (o_can_mode == 3'h1)) else $error("can decode wrong");
   a_lin_decode: assert property (o_lin_tx_on == (o_lin_mode == 2'h3) &&
      o_lin_rx_on == o_lin_mode[1] &&
      o_lin_wake_on == (o_lin_mode == 2'h1)) else $error("lin decode wrong");
   a_flag_write: assert property (run_ff && hit && !ev |=>
      {o_slope_bypass_flash, o_low_slope_select,
      o_tx_dominant_timeout_enable} == $past(i_reg_wdata[7:5]))
      else $error("flag write did not land");
   a_restart_txto: assert property (run_ff && !i_soft_reset &&
      i_restart |=> !o_tx_dominant_timeout_enable)
      else $error("restart left time-out enabled");
endmodule
bind btmc_top btmc_top_props u_props (.i_mclk, .i_rstn, .i_reg_addr,
   .i_reg_wr, .i_reg_wdata, .o_reg_rdata, .i_soft_reset, .i_restart,
   .i_restart_lin_hi, .i_failsafe_entry, .i_sleep_entry, .i_stop_entry,
   .i_system_error_enable, .i_sw_dev_mode, .o_lin_mode, .o_can_mode,
   .o_can_tx_on, .o_can_rx_on, .o_can_wake_on, .o_slope_bypass_flash,
   .o_low_slope_select, .o_tx_dominant_timeout_enable, .o_lin_tx_on,
   .o_lin_rx_on, .o_lin_wake_on);
`default_nettype wire

/* File: testbench/btmc_host_model.sv */
`default_nettype none
module btmc_host_model (
   input  wire logic        i_mclk,
   output logic      [6:0]  o_addr,
   output logic             o_wr,
   output logic             o_rd,
   output logic      [15:0] o_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {o_wr, o_rd, o_addr, o_wdata} = 25'h0;
   // one strobe cycle; released lines flip so stale values never match
   task automatic op(input logic w, input logic r, input logic [6:0] a,
                     input logic [15:0] d);
      @(negedge i_mclk);
      {o_wr, o_rd, o_addr, o_wdata} = {w, r, a, d};
      @(negedge i_mclk);
      {o_wr, o_rd} = 2'b00;
      o_addr = ~a;
      o_wdata = ~d;
   endtask
endmodule
`default_nettype wire

/* File: testbench/btmc_top_test.sv */
`include "btmc_map.svh"
`default_nettype none
module btmc_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [4:0]  ev = 5'h00;
   logic        lin_hi = 1'b0;
   logic        system_error_enable = 1'b0;
   logic        sdm = 1'b0;
   logic        pend = 1'b0;
   logic        wr, rd;
   logic [6:0]  addr;
   logic [15:0] wdata, rdata, v, x;
   logic [15:0] q[$];
   wire logic [7:0] fld;
   wire logic [5:0] en;
   logic        hitp = 1'b0;
   int          n_fail = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          seed = 25;
   always #5 clk = ~clk;
   btmc_host_model host (.i_mclk(clk), .o_addr(addr), .o_wr(wr),
      .o_rd(rd), .o_wdata(wdata));
   btmc_top DUT (.i_mclk(clk), .i_rstn(rstn), .i_reg_addr(addr),
      .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
      .i_soft_reset(ev[4]), .i_restart(ev[3]), .i_restart_lin_hi(lin_hi),
      .i_failsafe_entry(ev[2]), .i_sleep_entry(ev[1]), .i_stop_entry(ev[0]),
      .i_system_error_enable(system_error_enable), .i_sw_dev_mode(sdm),
      .o_slope_bypass_flash(fld[7]), .o_low_slope_select(fld[6]),
      .o_tx_dominant_timeout_enable(fld[5]), .o_lin_mode(fld[4:3]),
      .o_can_mode(fld[2:0]), .o_lin_tx_on(en[5]), .o_lin_rx_on(en[4]),
      .o_lin_wake_on(en[3]), .o_can_tx_on(en[2]), .o_can_rx_on(en[1]),
      .o_can_wake_on(en[0]));
   task automatic tally_and_finish;
      if (n_fail == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // a read edge raises pend; read data has settled by the falling edge;
   // hitp marks a plain register read, so the pins must match the word
   always @(posedge clk) begin
      pend <= rd;
      hitp <= rd & ~wr & (addr == `BTMC_ADDR);
   end
   always @(negedge clk) begin
      if (pend) begin
         x = (q.size() != 0) ? q.pop_front() : 16'hxxxx;
         comparisons++;
         if (rdata !== x) begin
            n_fail++;
            $display("BAD %0t read %h expected %h", $time, rdata, x);
         end
      end
      if (hitp) begin
         comparisons += 2;
         if (fld !== x[7:0]) begin
            n_fail++;
            $display("BAD %0t fields %h expected %h", $time, fld, x[7:0]);
         end
         if (en !== {x[4:3] == 2'h3, x[4], x[4:3] == 2'h1,
                     x[2:0] == 3'h3, x[2:1] == 2'h1, x[2:0] == 3'h1}) begin
            n_fail++;
            $display("BAD %0t enables %h for word %h", $time, en, x);
         end
      end
   end
   // a hang ends the run well past the roughly 150 cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [6:0] a, input logic [15:0] e);
      q.push_back(e);
      host.op(1'b0, 1'b1, a, 16'h0000);
   endtask
   // write a mode, pulse device events, read back the result
   task automatic evt(input logic [15:0] w, input logic [4:0] e,
                      input logic [15:0] r);
      host.op(1'b1, 1'b0, `BTMC_ADDR, w);
      ev = e;
      @(negedge clk);
      ev = 5'h00;
      chk(`BTMC_ADDR, r);
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(posedge clk);
      chk(`BTMC_ADDR, 16'h0000);
      host.op(1'b1, 1'b0, `BTMC_ADDR, 16'hffab);
      chk(`BTMC_ADDR, 16'h00ab);
      q.push_back(16'h00ab);
      host.op(1'b1, 1'b1, `BTMC_ADDR, 16'h0054);
      chk(`BTMC_ADDR, 16'h0054);
      host.op(1'b1, 1'b0, 7'h05, 16'h00ff);
      chk(7'h05, 16'h0000);
      chk(`BTMC_ADDR, 16'h0054);
      repeat (8) begin
         v = 16'($random(seed));
         host.op(1'b1, 1'b0, `BTMC_ADDR, v);
         chk(`BTMC_ADDR, {8'h00, v[7:0]});
      end
      evt(16'h00d3, 5'h02, 16'h00d1);
      system_error_enable = 1'b1;
      evt(16'h00d3, 5'h02, 16'h00d3);
      system_error_enable = 1'b0;
      evt(16'h00d7, 5'h02, 16'h00d5);
      evt(16'h00d2, 5'h02, 16'h00d1);
      evt(16'h00d2, 5'h01, 16'h00d2);
      evt(16'h00d3, 5'h01, 16'h00d3);
      evt(16'h00d1, 5'h02, 16'h00d1);
      evt(16'h00d4, 5'h01, 16'h00d4);
      evt(16'h0050, 5'h02, 16'h0050);
      lin_hi = 1'b1;
      evt(16'h00ff, 5'h08, 16'h00d4);
      lin_hi = 1'b0;
      evt(16'h00d3, 5'h0a, 16'h00c0);
      evt(16'h00e7, 5'h04, 16'h00ed);
      evt(16'h0012, 5'h04, 16'h0009);
      evt(16'h00ff, 5'h10, 16'h0000);
      sdm = 1'b1;
      evt(16'h00ff, 5'h10, 16'h0019);
      // let the last read be compared before reset clears the read data
      @(negedge clk);
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(posedge clk);
      chk(`BTMC_ADDR, 16'h0019);
      @(negedge clk);
      tally_and_finish();
   end
endmodule
`default_nettype wire
